// File: rcw_map.svh
// Register indices, field positions, reset values and timing counts of the reset-cause block.
`ifndef RCW_MAP_SVH
`define RCW_MAP_SVH

`define RCW_IDX_CAUSE      2'h0
`define RCW_IDX_DBGRST     2'h1
`define RCW_IDX_OPT1       2'h2
`define RCW_IDX_OPT2       2'h3

`define RCW_CAUSE_POR      7
`define RCW_CAUSE_PIN      6
`define RCW_CAUSE_WDOG     5
`define RCW_CAUSE_ILLEGAL_OPCODE_FLAG     4
`define RCW_CAUSE_OSC      2
`define RCW_CAUSE_BROWN    1
`define RCW_CAUSE_POWERON  8'h82

`define RCW_OPT1_PERIOD_HI 7
`define RCW_OPT1_PERIOD_LO 6
`define RCW_OPT1_HALT_EN   5
`define RCW_OPT1_RESET     8'hC0
`define RCW_OPT1_RDMASK    8'hF3
`define RCW_OPT2_SRC       7
`define RCW_OPT2_WIN       6
`define RCW_OPT2_RESET     8'h00
`define RCW_OPT2_RDMASK    8'hC0
`define RCW_DBG_FORCE_BIT  0

`define RCW_SVC_FIRST      8'h55
`define RCW_SVC_SECOND     8'hAA

`define RCW_BUS_OVF1       19'h02000
`define RCW_BUS_OVF2       19'h10000
`define RCW_BUS_OVF3       19'h40000
`define RCW_BUS_WIN1       19'h01800
`define RCW_BUS_WIN2       19'h0C000
`define RCW_BUS_WIN3       19'h30000
`define RCW_LPO_OVF1       19'h00020
`define RCW_LPO_OVF2       19'h00100
`define RCW_LPO_OVF3       19'h00400

`define RCW_HOLD_CYCLES    5'h10

`endif

// File: rcw_pkg.sv
// Types shared by the reset-cause and watchdog modules.
package rcw_pkg;
  typedef enum logic {RCW_RUN, RCW_HOLD} rcw_state_t;
  typedef logic [1:0]  rcw_period_t;
  typedef logic [18:0] rcw_count_t;
endpackage

// File: rcw_wdog_if.sv
// Signals between the reset controller and its watchdog counter.
`timescale 1ns/1ps
`default_nettype none
interface rcw_wdog_if;
  rcw_pkg::rcw_period_t periodSel;
  logic                 srcBus;
  logic                 lpoTick;
  logic                 restart;
  logic                 timeout;
  logic                 windowOpen;
  modport ctrl (output periodSel, output srcBus, output lpoTick, output restart,
                input timeout, input windowOpen);
  modport wdog (input periodSel, input srcBus, input lpoTick, input restart,
                output timeout, output windowOpen);
endinterface
`default_nettype wire

// File: rcw_watchdog.sv
// Watchdog counter with selectable source, overflow detection and service window.
`timescale 1ns/1ps
`default_nettype none
`include "rcw_map.svh"
module rcw_watchdog #(
  parameter rcw_pkg::rcw_count_t BUS_OVF1 = `RCW_BUS_OVF1,
  parameter rcw_pkg::rcw_count_t BUS_OVF2 = `RCW_BUS_OVF2,
  parameter rcw_pkg::rcw_count_t BUS_OVF3 = `RCW_BUS_OVF3,
  parameter rcw_pkg::rcw_count_t BUS_WIN1 = `RCW_BUS_WIN1,
  parameter rcw_pkg::rcw_count_t BUS_WIN2 = `RCW_BUS_WIN2,
  parameter rcw_pkg::rcw_count_t BUS_WIN3 = `RCW_BUS_WIN3
) (
  input wire logic clk_sys, // System bus clock.
  input wire logic reset_n, // Synchronous power-on reset, active low.
  rcw_wdog_if.wdog wd       // Control and status to the reset controller.
);
  rcw_pkg::rcw_count_t count_q;
  logic                tick;

  // Overflow count for a period setting; zero means disabled.
  function automatic rcw_pkg::rcw_count_t ovfOf(input rcw_pkg::rcw_period_t sel,
                                                 input logic bus);
    case (sel)
      2'h1:    ovfOf = bus ? BUS_OVF1 : `RCW_LPO_OVF1;
      2'h2:    ovfOf = bus ? BUS_OVF2 : `RCW_LPO_OVF2;
      2'h3:    ovfOf = bus ? BUS_OVF3 : `RCW_LPO_OVF3;
      default: ovfOf = 19'h00000;
    endcase
  endfunction

  // Window opening count; the slow source has no window, so it opens at zero.
  function automatic rcw_pkg::rcw_count_t winOf(input rcw_pkg::rcw_period_t sel,
                                                 input logic bus);
    case (sel)
      2'h1:    winOf = bus ? BUS_WIN1 : 19'h00000;
      2'h2:    winOf = bus ? BUS_WIN2 : 19'h00000;
      2'h3:    winOf = bus ? BUS_WIN3 : 19'h00000;
      default: winOf = 19'h00000;
    endcase
  endfunction

  // The bus source counts every edge, the slow source only on its tick.
  assign tick = (wd.periodSel != 2'h0) && (wd.srcBus || wd.lpoTick);
  assign wd.timeout = tick && (count_q == ovfOf(wd.periodSel, wd.srcBus) - 19'h00001);
  assign wd.windowOpen = count_q >= winOf(wd.periodSel, wd.srcBus);

  // Counter clears on reset, on restart and when disabled; it wraps at overflow.
  always_ff @(posedge clk_sys) begin
    if (!reset_n || wd.restart || wd.periodSel == 2'h0) begin
      count_q <= 19'h00000; // and
    end else if (wd.timeout) begin
      count_q <= 19'h00000;
    end else if (tick) begin
      count_q <= count_q + 19'h00001; // and
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_DISABLED_ZERO: assert property (wd.periodSel == 2'h0 |=> count_q == 19'h00000)
    else $error("Watchdog counter moved while disabled.");
  AST_RESTART_ZERO: assert property (wd.restart |=> count_q == 19'h00000)
    else $error("Watchdog restart did not clear the counter.");
  AST_BUS_SHORT_OVF: assert property (wd.periodSel == 2'h1 && wd.srcBus && !wd.restart
      && count_q == BUS_OVF1 - 19'h00001 |-> wd.timeout)
    else $error("Short bus period did not overflow at its count.");
endmodule
`default_nettype wire

// File: rcw_reset_ctrl.sv
// Reset-cause recorder, watchdog service, debug force reset and write-once system options.
//
// Functional notes
// - Reset cause register holds six read-only flags naming the last reset source.
// - A debug-forced reset leaves every reset cause flag cleared.
// - Watchdog service is 0x55 then 0xAA; with the watchdog enabled, any other write resets as watchdog.
// - Any write to the reset cause address restarts the watchdog; data not stored.
// - Power-on sets power-on flag bit 7 and brownout bit 1, clears the rest.
// - Low-voltage reset keeps power-on flag, sets brownout, clears the other flags.
// - Other resets set flags of active sources, clear the rest and power/brownout.
// - Bit 6 marks a reset from a low level on the external reset input.
// - Bit 5 marks a watchdog timeout; no such reset while watchdog is disabled.
// - Bit 4 marks illegal opcode, including blocked stop and blocked halt instruction.
// - Bit 2 marks external clock loss; bits 3 and 0 read zero.
// - Brownout bit 1 is set by low-voltage reset and by power-on.
// - Debug force reset register reads 0x00; program writes to it are ignored.
// - Debug host writing 1 to bit 0 of that register resets the device.
// - Options one is always readable; bits 3 and 2 read zero.
// - Options one takes only the first write after each reset.
// - Low-power halt enable resets to 0; stop while 0 is an illegal opcode reset.
// - Period 0 disables; bus clock periods 1..3 give 2^13, 2^16, 2^18 cycles.
// - Slow oscillator periods 1..3 give 2^5, 2^8, 2^10 cycles.
// - Bus-clock service window opens after 6144, 49152 or 196608 counts.
// - Write-once source select: 0 slow oscillator, 1 bus clock.
// - With window enabled on the bus clock source, any cause-address write in the first 75% resets.
`timescale 1ns/1ps
`default_nettype none
`include "rcw_map.svh"
module rcw_reset_ctrl #(
  parameter rcw_pkg::rcw_count_t BUS_OVF1 = `RCW_BUS_OVF1, // Overflow, bus period 1.
  parameter rcw_pkg::rcw_count_t BUS_OVF2 = `RCW_BUS_OVF2, // Overflow, bus period 2.
  parameter rcw_pkg::rcw_count_t BUS_OVF3 = `RCW_BUS_OVF3, // Overflow, bus period 3.
  parameter rcw_pkg::rcw_count_t BUS_WIN1 = `RCW_BUS_WIN1, // Window open, bus period 1.
  parameter rcw_pkg::rcw_count_t BUS_WIN2 = `RCW_BUS_WIN2, // Window open, bus period 2.
  parameter rcw_pkg::rcw_count_t BUS_WIN3 = `RCW_BUS_WIN3  // Window open, bus period 3.
) (
  input  wire logic       clk_sys,          // System bus clock.
  input  wire logic       reset_n,          // Power-on reset, synchronous, active low.
  input  wire logic [1:0] busAddr,          // Register index from the processor.
  input  wire logic       busWrite,         // Processor write strobe.
  input  wire logic       busRead,          // Processor read strobe.
  input  wire logic [7:0] busWrData,        // Processor write data.
  output logic      [7:0] busRdData,        // Registered read data.
  input  wire logic       dbgWrite,         // Debug host background write strobe.
  input  wire logic [1:0] dbgAddr,          // Debug host register index.
  input  wire logic [7:0] dbgWrData,        // Debug host write data.
  input  wire logic       slowOscTick,      // One-cycle pulse per slow oscillator period.
  input  wire logic       extReset_n,       // External reset input, active low.
  input  wire logic       lowVoltReset,     // Low-voltage reset request.
  input  wire logic       oscLost,          // Loss of external clock.
  input  wire logic       illegalOpcode,    // Unimplemented opcode executed.
  input  wire logic       haltInstrExec,    // Stop instruction executed.
  input  wire logic       bgndInstrExec,    // Background halt instruction executed.
  input  wire logic       debugModeEnable,  // Active background mode allowed.
  output logic            deviceReset,      // Device reset request, high while held.
  output logic            lowPowerHaltEnable // Stop mode allowed.
);
  rcw_wdog_if wdIf ();

  rcw_pkg::rcw_state_t state_q;
  logic [4:0] holdCnt_q;
  logic       deviceReset_q;
  logic [7:0] resetCause_q;
  logic [7:0] opt1_q;
  logic [7:0] opt2_q;
  logic       opt1Written_q;
  logic       opt2Written_q;
  logic       svcArmed_q;
  logic [7:0] busRdData_q;
  logic       running;
  logic       causeWrite;
  logic       watchdogEnable;
  logic       badService;
  logic       pinCause;
  logic       wdogCause;
  logic       ilopCause;
  logic       dbgCause;
  logic       anyCause;
  logic [7:0] nextCause;

  // Watchdog configuration comes from the write-once option registers.
  assign wdIf.periodSel = opt1_q[`RCW_OPT1_PERIOD_HI:`RCW_OPT1_PERIOD_LO];
  assign wdIf.srcBus    = opt2_q[`RCW_OPT2_SRC];
  assign wdIf.lpoTick   = slowOscTick;
  assign wdIf.restart   = causeWrite || !running; // and

  rcw_watchdog #(
    .BUS_OVF1 (BUS_OVF1),
    .BUS_OVF2 (BUS_OVF2),
    .BUS_OVF3 (BUS_OVF3),
    .BUS_WIN1 (BUS_WIN1),
    .BUS_WIN2 (BUS_WIN2),
    .BUS_WIN3 (BUS_WIN3)
  ) uWatchdog (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .wd      (wdIf)
  );

  // Bus writes only act while the device is out of reset.
  assign running        = (state_q == rcw_pkg::RCW_RUN);
  assign causeWrite     = running && busWrite && busAddr == `RCW_IDX_CAUSE;
  assign watchdogEnable = (wdIf.periodSel != 2'h0);

  // A wrong value, a second byte without the first, or an early write in window mode.
  // The window only exists for the bus source, so the slow source is never early.
  assign badService = causeWrite && watchdogEnable && (
      (busWrData != `RCW_SVC_FIRST && busWrData != `RCW_SVC_SECOND) ||
      (busWrData == `RCW_SVC_SECOND && !svcArmed_q) ||
      (opt2_q[`RCW_OPT2_WIN] && !wdIf.windowOpen)); // and and

  // Reset sources sampled in the running state.
  assign pinCause  = !extReset_n;
  assign wdogCause = wdIf.timeout || badService;
  assign ilopCause = illegalOpcode ||
                     (haltInstrExec && !opt1_q[`RCW_OPT1_HALT_EN]) ||
                     (bgndInstrExec && !debugModeEnable); // and
  assign dbgCause  = dbgWrite && dbgAddr == `RCW_IDX_DBGRST &&
                     dbgWrData[`RCW_DBG_FORCE_BIT];
  assign anyCause  = pinCause || wdogCause || ilopCause || oscLost ||
                     lowVoltReset || dbgCause;

  // Cause pattern for a reset entered now; a debug force adds no flag of its own.
  always_comb begin
    nextCause = 8'h00; // and
    if (lowVoltReset) begin
      nextCause[`RCW_CAUSE_POR]   = resetCause_q[`RCW_CAUSE_POR];
      nextCause[`RCW_CAUSE_BROWN] = 1'b1;
    end else begin
      nextCause[`RCW_CAUSE_PIN]  = pinCause;
      nextCause[`RCW_CAUSE_WDOG] = wdogCause;
      nextCause[`RCW_CAUSE_ILLEGAL_OPCODE_FLAG] = ilopCause;
      nextCause[`RCW_CAUSE_OSC]  = oscLost;
    end
  end

  // Reset sequencer: any source starts a fixed hold; a low reset pin stretches it.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q       <= rcw_pkg::RCW_RUN;
      holdCnt_q     <= 5'h00;
      deviceReset_q <= 1'b0;
    end else begin
      case (state_q)
        rcw_pkg::RCW_RUN: begin
          if (anyCause) begin
            state_q       <= rcw_pkg::RCW_HOLD;
            holdCnt_q     <= `RCW_HOLD_CYCLES - 5'h01;
            deviceReset_q <= 1'b1;
          end
        end
        rcw_pkg::RCW_HOLD: begin
          if (pinCause) begin
            holdCnt_q <= `RCW_HOLD_CYCLES - 5'h01;
          end else if (holdCnt_q == 5'h00) begin
            state_q       <= rcw_pkg::RCW_RUN;
            deviceReset_q <= 1'b0;
          end else begin
            holdCnt_q <= holdCnt_q - 5'h01;
          end
        end
        default: begin
          state_q       <= rcw_pkg::RCW_RUN;
          deviceReset_q <= 1'b0;
        end
      endcase
    end
  end

  // The cause register is loaded once per reset and never by a bus write.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      resetCause_q <= `RCW_CAUSE_POWERON; // and
    end else if (running && anyCause) begin
      resetCause_q <= nextCause; // and
    end
  end

  // Service sequence tracker; a reset drops any half-done sequence.
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !running) begin
      svcArmed_q <= 1'b0;
    end else if (causeWrite) begin
      svcArmed_q <= (busWrData == `RCW_SVC_FIRST);
    end
  end

  // Option registers return to defaults on every reset, then take one write each.
  // Locking guards these settings against a runaway program rewriting them.
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !running) begin
      opt1_q        <= `RCW_OPT1_RESET;
      opt1Written_q <= 1'b0;
    end else if (busWrite && busAddr == `RCW_IDX_OPT1 && !opt1Written_q) begin
      opt1_q        <= busWrData & `RCW_OPT1_RDMASK;
      opt1Written_q <= 1'b1; // and
    end
  end

  // Second option register holds the watchdog source and window bits, also write-once.
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !running) begin
      opt2_q        <= `RCW_OPT2_RESET;
      opt2Written_q <= 1'b0;
    end else if (busWrite && busAddr == `RCW_IDX_OPT2 && !opt2Written_q) begin
      opt2_q        <= busWrData & `RCW_OPT2_RDMASK; // and
      opt2Written_q <= 1'b1;
    end
  end

  // Read data is registered; the debug force register always reads zero.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      busRdData_q <= 8'h00;
    end else if (busRead) begin
      case (busAddr)
        `RCW_IDX_CAUSE:  busRdData_q <= resetCause_q;
        `RCW_IDX_DBGRST: busRdData_q <= 8'h00;
        `RCW_IDX_OPT1:   busRdData_q <= opt1_q & `RCW_OPT1_RDMASK;
        `RCW_IDX_OPT2:   busRdData_q <= opt2_q & `RCW_OPT2_RDMASK;
        default:         busRdData_q <= 8'h00;
      endcase
    end else begin
      busRdData_q <= 8'h00;
    end
  end

  // Outputs leave straight from their flip-flops.
  assign busRdData          = busRdData_q;
  assign deviceReset        = deviceReset_q;
  assign lowPowerHaltEnable = opt1_q[`RCW_OPT1_HALT_EN];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_DBG_CLEARS: assert property (
      running && dbgCause && extReset_n && !lowVoltReset && !oscLost && !ilopCause
      && !wdogCause |=> resetCause_q == 8'h00 && deviceReset_q)
    else $error("Debug forced reset left a cause flag set.");
  AST_BAD_SVC_RESETS: assert property (
      causeWrite && watchdogEnable && !lowVoltReset &&
      busWrData != `RCW_SVC_FIRST && busWrData != `RCW_SVC_SECOND
      |=> deviceReset_q && resetCause_q[`RCW_CAUSE_WDOG])
    else $error("Bad service value did not cause a watchdog reset.");
  AST_LVR_KEEPS_POR: assert property (
      running && lowVoltReset |=> resetCause_q[7] == $past(resetCause_q[7])
      && resetCause_q[1] && resetCause_q[6:2] == 5'h00 && !resetCause_q[0])
    else $error("Low-voltage reset produced a wrong cause pattern.");
  AST_PIN_FLAG: assert property (
      running && !extReset_n && !lowVoltReset
      |=> resetCause_q[`RCW_CAUSE_PIN] && !resetCause_q[`RCW_CAUSE_POR])
    else $error("External reset did not set its flag.");
  AST_ILLEGAL_OPCODE_FLAG_STOP: assert property (
      running && haltInstrExec && !opt1_q[`RCW_OPT1_HALT_EN] && !lowVoltReset
      |=> resetCause_q[`RCW_CAUSE_ILLEGAL_OPCODE_FLAG] && deviceReset_q)
    else $error("Blocked stop did not give an illegal opcode reset.");
  AST_RSVD_ZERO: assert property (!resetCause_q[3] && !resetCause_q[0])
    else $error("Unused cause bits are not zero.");
  AST_DBG_READ_ZERO: assert property (
      busRead && busAddr == `RCW_IDX_DBGRST |=> busRdData_q == 8'h00)
    else $error("Debug force register read was not zero.");
  AST_OPT1_ONCE: assert property (
      running && opt1Written_q && busWrite && busAddr == `RCW_IDX_OPT1 && !anyCause
      |=> opt1_q == $past(opt1_q))
    else $error("Second options write was honoured.");
  AST_OPT1_READ: assert property (
      busRead && busAddr == `RCW_IDX_OPT1 |=> busRdData_q[3:2] == 2'h0
      && busRdData_q[7:4] == $past(opt1_q[7:4]))
    else $error("Options one read returned wrong data.");
  AST_HOLD_LEN: assert property ($rose(deviceReset_q) |-> deviceReset_q[*8])
    else $error("Device reset was held too briefly.");
  AST_DISABLED_NO_WDOG: assert property (
      running && !watchdogEnable |-> !wdogCause)
    else $error("Watchdog reset raised while the watchdog is disabled.");

  // Flags, option locking and stop permission around reset entry.
  AST_WDOG_TIMEOUT_FLAG: assert property (
      running && wdIf.timeout && !lowVoltReset
      |=> deviceReset_q && resetCause_q[`RCW_CAUSE_WDOG])
    else $error("Watchdog timeout did not give a watchdog reset.");
  AST_OSC_FLAG: assert property (
      running && oscLost && !lowVoltReset
      |=> resetCause_q[`RCW_CAUSE_OSC] && !resetCause_q[`RCW_CAUSE_BROWN])
    else $error("Clock loss did not set its flag alone.");
  AST_CAUSE_NOT_WRITTEN: assert property (
      causeWrite && !anyCause |=> resetCause_q == $past(resetCause_q))
    else $error("A service write altered the cause flags.");
  AST_OPT2_ONCE: assert property (
      running && opt2Written_q && busWrite && busAddr == `RCW_IDX_OPT2 && !anyCause
      |=> opt2_q == $past(opt2_q))
    else $error("Second write to options two was honoured.");
  AST_OPT1_LOCKS: assert property (
      running && busWrite && busAddr == `RCW_IDX_OPT1 && !anyCause |=> opt1Written_q)
    else $error("Options one did not lock after a write.");
  AST_HALT_OFF_IN_RESET: assert property (!running |=> !opt1_q[`RCW_OPT1_HALT_EN])
    else $error("Stop permission survived a device reset.");
  AST_DBG_FORCES: assert property (
      running && dbgCause |=> deviceReset_q)
    else $error("Debug force did not reset the device.");
endmodule
`default_nettype wire

// File: rcw_debug_host.sv
// Behavioural model of the external debug host that sends background write commands.
`timescale 1ns/1ps
`default_nettype none
module rcw_debug_host (
  input  wire logic       clk_sys,   // System bus clock.
  output logic            dbgWrite,  // Background write strobe.
  output logic      [1:0] dbgAddr,   // Register index of the command.
  output logic      [7:0] dbgWrData  // Command data.
);
  // Idle lines show the inverse of the last value so stale data is never mistaken for a command.
  initial begin
    dbgWrite  = 1'b0;
    dbgAddr   = 2'h2;
    dbgWrData = 8'hFE;
  end

  // Only this path reaches the force reset register; writing bit 0 high forces a reset.
  task automatic send(input logic [1:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    #1;
    dbgWrite  = 1'b1;
    dbgAddr   = addr;
    dbgWrData = data;
    @(posedge clk_sys);
    #1;
    dbgWrite  = 1'b0;
    dbgAddr   = ~addr;
    dbgWrData = ~data;
  endtask
endmodule
`default_nettype wire

// File: rcw_reset_ctrl_test.sv
// Self-checking testbench for the reset-cause and watchdog controller.
`timescale 1ns/1ps
`default_nettype none
module rcw_reset_ctrl_test;
  localparam rcw_pkg::rcw_count_t OVF1 = 19'h00040;
  localparam rcw_pkg::rcw_count_t WIN1 = 19'h00030;
  logic       clk_sys = 1'b0;
  logic       reset_n = 1'b0;
  logic [1:0] busAddr = 2'h0;
  logic       busWrite = 1'b0;
  logic       busRead = 1'b0;
  logic [7:0] busWrData = 8'h00;
  logic [7:0] busRdData;
  logic       dbgWrite;
  logic [1:0] dbgAddr;
  logic [7:0] dbgWrData;
  logic       slowOscTick = 1'b0;
  logic [4:0] srcSet = 5'h00;
  logic       lowVoltReset = 1'b0;
  logic       debugModeEnable = 1'b0;
  logic       deviceReset;
  logic       lowPowerHaltEnable;
  logic       tickOn = 1'b0;
  logic [1:0] tickCnt = 2'h0;
  logic [7:0] rdVal;
  int         mismatches = 0;
  int         total_checks = 0;

  always #20 clk_sys = ~clk_sys;

  // Slow oscillator stand-in: one pulse every fourth cycle while enabled.
  always @(posedge clk_sys) begin
    #1;
    tickCnt = tickCnt + 2'h1;
    slowOscTick = tickOn && (tickCnt == 2'h0);
  end

  rcw_reset_ctrl #(.BUS_OVF1(OVF1), .BUS_OVF2(19'h00080), .BUS_OVF3(19'h00100),
    .BUS_WIN1(WIN1), .BUS_WIN2(19'h00060), .BUS_WIN3(19'h000C0)) rcw_reset_ctrl_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .busAddr(busAddr), .busWrite(busWrite),
    .busRead(busRead), .busWrData(busWrData), .busRdData(busRdData), .dbgWrite(dbgWrite),
    .dbgAddr(dbgAddr), .dbgWrData(dbgWrData), .slowOscTick(slowOscTick),
    .extReset_n(~srcSet[0]), .lowVoltReset(lowVoltReset), .oscLost(srcSet[1]),
    .illegalOpcode(srcSet[2]), .haltInstrExec(srcSet[3]), .bgndInstrExec(srcSet[4]),
    .debugModeEnable(debugModeEnable), .deviceReset(deviceReset),
    .lowPowerHaltEnable(lowPowerHaltEnable));

  rcw_debug_host rcw_debug_host_inst (.clk_sys(clk_sys), .dbgWrite(dbgWrite),
    .dbgAddr(dbgAddr), .dbgWrData(dbgWrData));

  // One comparison; a mismatch is printed at once and counted.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [1:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    #1;
    busWrite = 1'b1;
    busAddr = addr;
    busWrData = data;
    @(posedge clk_sys);
    #1;
    busWrite = 1'b0;
  endtask

  // Read data is registered, so it is taken just after the edge that accepts the read.
  task automatic rd(input logic [1:0] addr);
    @(posedge clk_sys);
    #1;
    busRead = 1'b1;
    busAddr = addr;
    @(posedge clk_sys);
    #1;
    busRead = 1'b0;
    rdVal = busRdData;
  endtask

  // Bounded wait for the reset request to reach a level; the caller compares afterwards.
  task automatic waitFor(input logic lvl, input int lim);
    for (int i = 0; i < lim && deviceReset !== lvl; i++) @(posedge clk_sys);
    #2;
  endtask

  // Pulse one reset source for a cycle, let the hold run out, then compare the cause.
  task automatic fire(input int k, input logic [7:0] exp);
    @(posedge clk_sys);
    #1;
    srcSet[k] = 1'b1;
    @(posedge clk_sys);
    #1;
    srcSet[k] = 1'b0;
    waitFor(1'b0, 200);
    rd(2'h0);
    chk(rdVal, exp);
  endtask

  // Debug force reset is the quickest way back to default, unlocked options.
  task automatic dbgReset();
    rcw_debug_host_inst.send(2'h1, 8'h01);
    chk({7'h0, deviceReset}, 8'h01);
    waitFor(1'b0, 200);
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    rd(2'h0);
    chk(rdVal, 8'h82);
    rd(2'h2);
    chk(rdVal, 8'hC0);
    rd(2'h3);
    chk(rdVal, 8'h00);
    rd(2'h1);
    chk(rdVal, 8'h00);
    chk({7'h0, lowPowerHaltEnable}, 8'h00);
    // A low-voltage reset keeps the power-on flag only while it is still set.
    @(posedge clk_sys);
    #1;
    lowVoltReset = 1'b1;
    @(posedge clk_sys);
    #1;
    lowVoltReset = 1'b0;
    waitFor(1'b0, 200);
    rd(2'h0);
    chk(rdVal, 8'h82);
    // Pin, clock loss, illegal opcode, blocked stop and blocked halt, one at a time.
    fire(0, 8'h40);
    fire(1, 8'h04);
    fire(2, 8'h10);
    fire(3, 8'h10);
    fire(4, 8'h10);
    @(posedge clk_sys);
    #1;
    lowVoltReset = 1'b1;
    @(posedge clk_sys);
    #1;
    lowVoltReset = 1'b0;
    waitFor(1'b0, 200);
    rd(2'h0);
    chk(rdVal, 8'h02);
    // A program write to the force reset register must do nothing.
    wr(2'h1, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk({7'h0, deviceReset}, 8'h00);
    dbgReset();
    rd(2'h0);
    chk(rdVal, 8'h00);
    // Options one: first write taken, later ones ignored, bits 3 and 2 read zero.
    wr(2'h2, 8'h73);
    wr(2'h2, 8'hFF);
    rd(2'h2);
    chk(rdVal, 8'h73);
    chk({7'h0, lowPowerHaltEnable}, 8'h01);
    debugModeEnable = 1'b1;
    fire(3, 8'h00);
    fire(4, 8'h00);
    wr(2'h3, 8'h80);
    // Regular service on the bus clock keeps the watchdog quiet.
    repeat (4) begin
      wr(2'h0, 8'h55);
      wr(2'h0, 8'hAA);
      repeat (30) @(posedge clk_sys);
    end
    chk({7'h0, deviceReset}, 8'h00);
    repeat (OVF1 - 36) @(posedge clk_sys);
    chk({7'h0, deviceReset}, 8'h00);
    waitFor(1'b1, 16);
    chk({7'h0, deviceReset}, 8'h01);
    waitFor(1'b0, 200);
    rd(2'h0);
    chk(rdVal, 8'h20);
    // A wrong value, and a second half with no first half, both reset as the watchdog.
    for (int i = 0; i < 2; i++) begin
      wr(2'h0, i == 0 ? 8'h12 : 8'hAA);
      waitFor(1'b1, 4);
      chk({7'h0, deviceReset}, 8'h01);
      waitFor(1'b0, 200);
      rd(2'h0);
      chk(rdVal, 8'h20);
    end
    // With the period field at zero the watchdog is off and bad writes do nothing.
    wr(2'h2, 8'h00);
    wr(2'h0, 8'h12);
    repeat (4) @(posedge clk_sys);
    chk({7'h0, deviceReset}, 8'h00);
    dbgReset();
    // Windowed mode: an early write resets, a write after the window opens does not.
    wr(2'h3, 8'hC0);
    wr(2'h2, 8'h40);
    wr(2'h0, 8'h55);
    waitFor(1'b1, 4);
    chk({7'h0, deviceReset}, 8'h01);
    waitFor(1'b0, 200);
    wr(2'h3, 8'hC0);
    wr(2'h2, 8'h40);
    repeat (WIN1 + 2) @(posedge clk_sys);
    wr(2'h0, 8'h55);
    repeat (3) @(posedge clk_sys);
    chk({7'h0, deviceReset}, 8'h00);
    dbgReset();
    // Slow source, period one: overflow after 32 ticks of four cycles each.
    wr(2'h2, 8'h40);
    tickOn = 1'b1;
    repeat (28 * 4) @(posedge clk_sys);
    chk({7'h0, deviceReset}, 8'h00);
    waitFor(1'b1, 40);
    chk({7'h0, deviceReset}, 8'h01);
    tickOn = 1'b0;
    waitFor(1'b0, 200);
    rd(2'h0);
    chk(rdVal, 8'h20);
    summarize();
  end

  // The whole sequence needs well under a thousand cycles; this limit leaves a wide margin.
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
